// >>> pkg/pmu_cfg.svh
// Constants for the power state control block: offsets, fields, resets, timing.
`ifndef PMU_CFG_SVH
`define PMU_CFG_SVH
`define PMU_ADDR_CONTROL 12'h000
`define PMU_ADDR_CORE_VOLT 12'h004
`define PMU_ADDR_RETENTION 12'h008
`define PMU_ADDR_MODE_FORCE 12'h00C
`define PMU_ADDR_STATUS 12'h010
`define PMU_ADDR_SENSE 12'h014
`define PMU_CORE_VOLT_RESET 7'h7F
`define PMU_RETENTION_RESET 7'h00
`define PMU_FORCE_PWM_BIT 0
`define PMU_FORCE_PFM_BIT 1
`define PMU_LIGHT_LOAD_CYCLES 6'h20
`define PMU_SYS_CLK_HZ 40000000
`define PMU_PWM_FREQ_HZ 1000000
`define PMU_PWM_PERIOD_CYCLES (`PMU_SYS_CLK_HZ / `PMU_PWM_FREQ_HZ)
`define PMU_PWM_HIGH_CYCLES 6'h14
`define PMU_PFM_LIMIT_MA 100
`define PMU_NORMAL_LIMIT_MA 400
`define PMU_POWERUP_CYCLES 8'h40
`define PMU_CMD_CORE_ADJ 4'h1
`define PMU_CMD_RESET 4'h2
`define PMU_CMD_SLEEP 4'h3
`define PMU_CMD_SHUTDOWN 4'h4
`define PMU_CMD_WAKEUP 4'h5
`define PMU_CMD_REG_READ 4'h6
`define PMU_CMD_REG_WRITE 4'h7
`define PMU_CMD_AUTH 4'h8
`define PMU_CMD_SYNC 4'h9
`define PMU_AUTH_CODE 8'h5A
`endif

// >>> pkg/pmu_pkg.sv
// Types shared by the power state control block.
package pmu_pkg;
	typedef enum logic [1:0] {
		PMU_STARTUP,
		PMU_ACTIVE,
		PMU_SLEEP,
		PMU_SHUTDOWN
	} pmu_state_t;
	typedef struct packed {
		logic core_en;
		logic retention_en;
		logic pll_regulator;
		logic io_regulator;
	} pmu_reg_en_t;
	typedef struct packed {
		logic valid;
		logic [3:0] opcode;
		logic [7:0] payload;
	} pmu_cmd_t;
endpackage : pmu_pkg

// >>> rtl/pmu_ctrl.sv
// Power state machine, link command decoder, converter mode and APB registers.
`timescale 1ns/1ps
`include "pmu_cfg.svh"
module pmu_ctrl (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic enable_pin,
	input wire logic global_reset_n,
	input wire logic link_clk,
	input wire logic link_data_in,
	output logic link_data_out,
	output logic link_data_oe,
	input wire logic valley_below_zero,
	input wire logic peak_below_mode,
	input wire logic out_below_pfm_high,
	input wire logic peak_above_limit,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic power_good_out,
	output pmu_pkg::pmu_reg_en_t reg_enable,
	output logic [6:0] core_volt_code,
	output logic [6:0] retention_supply_out,
	output logic high_side_on,
	output logic low_side_on,
	output logic pulse_frequency_mode,
	output logic [8:0] current_limit_ma
);
	logic [1:0] en_sync;
	logic [1:0] rst_sync;
	logic [1:0] lclk_sync;
	logic [1:0] ldat_sync;
	logic lclk_prev;
	pmu_pkg::pmu_state_t state;
	pmu_pkg::pmu_state_t next_state;
	logic [7:0] pu_count;
	logic link_off;
	logic [12:0] shift;
	logic [3:0] bit_count;
	pmu_pkg::pmu_cmd_t cmd;
	logic authenticated;
	logic [6:0] core_prog;
	logic [6:0] retention_prog;
	logic [1:0] mode_force;
	logic [5:0] light_count;
	logic [5:0] pwm_count;
	logic [7:0] reply;
	logic [3:0] reply_count;
	logic pins_ok;
	logic lclk_rise;
	logic cmd_sleep;
	logic cmd_shutdown;
	logic cmd_wakeup;
	logic light_load;
	logic in_pulse_mode;
	logic bus_write;
	logic bus_read;

	function automatic logic is_cmd(input pmu_pkg::pmu_cmd_t c,
		input logic [3:0] op);
		is_cmd = c.valid && c.opcode == op;
	endfunction : is_cmd

	// Enable, reset and link inputs pass two flops before anything reads them; the comparator inputs are read directly.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			en_sync <= 2'h0;
			rst_sync <= 2'h0;
			lclk_sync <= 2'h0;
			ldat_sync <= 2'h0;
			lclk_prev <= 1'b0;
		end else begin
			en_sync <= {en_sync[0], enable_pin};
			rst_sync <= {rst_sync[0], global_reset_n};
			lclk_sync <= {lclk_sync[0], link_clk};
			ldat_sync <= {ldat_sync[0], link_data_in};
			lclk_prev <= lclk_sync[1];
		end
	end

	assign pins_ok = en_sync[1] && rst_sync[1];
	assign lclk_rise = lclk_sync[1] && !lclk_prev;
	assign cmd_sleep = is_cmd(cmd, `PMU_CMD_SLEEP);
	assign cmd_shutdown = is_cmd(cmd, `PMU_CMD_SHUTDOWN);
	assign cmd_wakeup = is_cmd(cmd, `PMU_CMD_WAKEUP);

	always_comb begin
		next_state = state;
		case (state)
			pmu_pkg::PMU_STARTUP: begin
				if (pins_ok && pu_count == `PMU_POWERUP_CYCLES) begin
					next_state = pmu_pkg::PMU_ACTIVE;
				end
			end
			pmu_pkg::PMU_ACTIVE: begin
				if (!pins_ok || cmd_shutdown) begin
					next_state = pmu_pkg::PMU_SHUTDOWN;
				end else if (cmd_sleep) begin
					next_state = pmu_pkg::PMU_SLEEP;
				end
			end
			pmu_pkg::PMU_SLEEP: begin
				if (!pins_ok || cmd_shutdown) begin
					next_state = pmu_pkg::PMU_SHUTDOWN;
				end else if (cmd_wakeup) begin
					next_state = pmu_pkg::PMU_ACTIVE;
				end
			end
			pmu_pkg::PMU_SHUTDOWN: begin
				if (!pins_ok) begin
					next_state = pmu_pkg::PMU_STARTUP;
				end
			end
			default: next_state = pmu_pkg::PMU_STARTUP;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= pmu_pkg::PMU_STARTUP;
		end else begin
			state <= next_state;
		end
	end

	// Power-up sequence counter runs only while enabled in start-up.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pu_count <= 8'h00;
		end else if (state != pmu_pkg::PMU_STARTUP || !pins_ok) begin
			pu_count <= 8'h00;
		end else if (pu_count != `PMU_POWERUP_CYCLES) begin
			pu_count <= pu_count + 8'h01;
		end
	end

	// The link stays dead after a shutdown command until a pin drops and start-up then sees both pins high.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			link_off <= 1'b1;
		end else if (!pins_ok) begin
			link_off <= 1'b1;
		end else if (state == pmu_pkg::PMU_STARTUP) begin
			link_off <= 1'b0;
		end else if (cmd_shutdown) begin
			link_off <= 1'b1;
		end
	end

	// Frames are 13 bits MSB first: a start bit, then opcode, then payload.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			shift <= 13'h0000;
			bit_count <= 4'h0;
			cmd <= '0;
		end else begin
			cmd.valid <= 1'b0;
			if (link_off) begin
				bit_count <= 4'h0;
			end else if (lclk_rise && reply_count == 4'h0 &&
				!link_data_oe) begin
				// Rises that clock a reply out belong to no command frame.
				if (bit_count == 4'hC) begin
					bit_count <= 4'h0;
					cmd.valid <= 1'b1;
					// The last payload bit is still at the input, not in shift.
					cmd.opcode <= shift[10:7];
					cmd.payload <= {shift[6:0], ldat_sync[1]};
				end else begin
					bit_count <= bit_count + 4'h1;
				end
				shift <= {shift[11:0], ldat_sync[1]};
			end
		end
	end

	// Register read answers are shifted out on following link clocks.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reply <= 8'h00;
			reply_count <= 4'h0;
			link_data_out <= 1'b0;
			link_data_oe <= 1'b0;
		end else if (link_off) begin
			reply_count <= 4'h0;
			link_data_oe <= 1'b0;
			link_data_out <= 1'b0;
		end else if (is_cmd(cmd, `PMU_CMD_REG_READ)) begin
			reply_count <= 4'h8;
			reply <= cmd.payload[0] ? {1'b0, retention_prog} :
				{1'b0, core_prog};
		end else if (lclk_rise && reply_count != 4'h0) begin
			link_data_oe <= 1'b1;
			link_data_out <= reply[7];
			reply <= {reply[6:0], 1'b0};
			reply_count <= reply_count - 4'h1;
		end else if (lclk_rise) begin
			link_data_oe <= 1'b0;
			link_data_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			authenticated <= 1'b0;
		end else if (is_cmd(cmd, `PMU_CMD_AUTH)) begin
			authenticated <= cmd.payload == `PMU_AUTH_CODE;
		end else if (is_cmd(cmd, `PMU_CMD_SYNC) || link_off) begin
			authenticated <= 1'b0;
		end
	end

	assign bus_write = psel && penable && pwrite;
	assign bus_read = psel && penable && !pwrite;

	// Programmed settings; start-up restores the defaults.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			core_prog <= `PMU_CORE_VOLT_RESET;
			retention_prog <= `PMU_RETENTION_RESET;
			mode_force <= 2'h0;
		end else if (state == pmu_pkg::PMU_STARTUP) begin
			core_prog <= `PMU_CORE_VOLT_RESET;
			retention_prog <= `PMU_RETENTION_RESET;
			mode_force <= 2'h0;
		end else if (is_cmd(cmd, `PMU_CMD_CORE_ADJ)) begin
			core_prog <= cmd.payload[6:0];
		end else if (is_cmd(cmd, `PMU_CMD_RESET)) begin
			core_prog <= `PMU_CORE_VOLT_RESET;
			retention_prog <= `PMU_RETENTION_RESET;
			mode_force <= 2'h0;
		end else if (is_cmd(cmd, `PMU_CMD_REG_WRITE) && authenticated) begin
			if (cmd.payload[7]) begin
				retention_prog <= cmd.payload[6:0];
			end else begin
				mode_force <= cmd.payload[1:0];
			end
		end else if (bus_write) begin
			case (paddr)
				`PMU_ADDR_CORE_VOLT: core_prog <= pwdata[6:0];
				`PMU_ADDR_RETENTION: retention_prog <= pwdata[6:0];
				`PMU_ADDR_MODE_FORCE: mode_force <= pwdata[1:0];
				default: core_prog <= core_prog;
			endcase
		end
	end

	// Light-load persistence counter for automatic mode.
	assign light_load = valley_below_zero || peak_below_mode;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			light_count <= 6'h00;
		end else if (!light_load) begin
			light_count <= 6'h00;
		end else if (light_count != `PMU_LIGHT_LOAD_CYCLES) begin
			light_count <= light_count + 6'h01;
		end
	end

	always_comb begin
		case (mode_force)
			2'b10: in_pulse_mode = 1'b1;
			2'b01: in_pulse_mode = 1'b0;
			default: in_pulse_mode =
				light_count == `PMU_LIGHT_LOAD_CYCLES;
		endcase
	end

	// PWM period counter: first part high-side, rest low-side.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pwm_count <= 6'h00;
		end else if (state != pmu_pkg::PMU_ACTIVE || in_pulse_mode) begin
			// Restarting here makes every PWM run open with a high phase.
			pwm_count <= 6'h00;
		end else if (pwm_count == 6'(`PMU_PWM_PERIOD_CYCLES - 1)) begin
			pwm_count <= 6'h00;
		end else begin
			pwm_count <= pwm_count + 6'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			high_side_on <= 1'b0;
			low_side_on <= 1'b0;
			pulse_frequency_mode <= 1'b0;
			current_limit_ma <= 9'h000;
		end else begin
			pulse_frequency_mode <= in_pulse_mode;
			current_limit_ma <= (mode_force == 2'b10) ?
				9'(`PMU_PFM_LIMIT_MA) :
				9'(`PMU_NORMAL_LIMIT_MA);
			if (state != pmu_pkg::PMU_ACTIVE) begin
				high_side_on <= 1'b0;
				low_side_on <= 1'b0;
			end else if (in_pulse_mode) begin
				high_side_on <= out_below_pfm_high &&
					!peak_above_limit;
				low_side_on <= 1'b0;
			end else begin
				high_side_on <= pwm_count < `PMU_PWM_HIGH_CYCLES;
				low_side_on <= pwm_count >= `PMU_PWM_HIGH_CYCLES;
			end
		end
	end

	// Regulator enables and output codes per operating state.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			power_good_out <= 1'b0;
			reg_enable <= '0;
			core_volt_code <= 7'h00;
			retention_supply_out <= 7'h00;
		end else begin
			case (next_state)
				pmu_pkg::PMU_ACTIVE: begin
					power_good_out <= 1'b1;
					reg_enable <= 4'hF;
					core_volt_code <= core_prog;
					retention_supply_out <= core_prog;
				end
				pmu_pkg::PMU_SLEEP: begin
					power_good_out <= 1'b1;
					reg_enable <= 4'h7;
					core_volt_code <= 7'h00;
					retention_supply_out <= retention_prog;
				end
				default: begin
					power_good_out <= 1'b0;
					reg_enable <= 4'h0;
					core_volt_code <= 7'h00;
					retention_supply_out <= 7'h00;
				end
			endcase
		end
	end

	// APB slave: one wait-free access phase, unmapped reads give zero.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				case (paddr)
					`PMU_ADDR_CONTROL: prdata <= {31'h0, link_off};
					`PMU_ADDR_CORE_VOLT: prdata <= {25'h0, core_prog};
					`PMU_ADDR_RETENTION: prdata <= {25'h0, retention_prog};
					`PMU_ADDR_MODE_FORCE: prdata <= {30'h0, mode_force};
					`PMU_ADDR_STATUS: prdata <= {27'h0, in_pulse_mode,
						authenticated, pins_ok, state};
					`PMU_ADDR_SENSE: prdata <= {26'h0, light_count};
					default: begin
						prdata <= 32'h00000000;
						pslverr <= pwrite;
					end
				endcase
			end
		end
	end
endmodule : pmu_ctrl

// >>> sim/pmu_link_host.sv
// Model of the power controller that frames link commands and reads replies.
`timescale 1ns/1ps
module pmu_link_host (
	output logic link_clk,
	output logic link_data,
	input wire logic link_line,
	input wire logic link_oe
);
	initial begin
		link_clk = 1'h0;
		link_data = 1'h1;
	end
	// The link clock runs only inside a frame or a reply read; it is held low between them.
	task automatic send(input logic [3:0] op, input logic [7:0] pl);
		logic [12:0] f;
		f = {1'h1, op, pl};
		#7;
		for (int i = 12; i >= 0; i--) begin
			link_data = f[i];
			#100 link_clk = 1'h1;
			#100 link_clk = 1'h0;
		end
		link_data = ~link_data;
		#400;
	endtask : send
	// Each reply bit is taken just before the rise that follows its launch.
	task automatic reply(output logic [7:0] v);
		v = 8'h00;
		for (int i = 0; i < 9; i++) begin
			#100;
			if (i > 0) begin
				v[8 - i] = link_oe ? link_line : 1'hX;
			end
			link_clk = 1'h1;
			#100 link_clk = 1'h0;
			link_data = ~link_data;
		end
		#400;
	endtask : reply
endmodule : pmu_link_host

// >>> sim/pmu_ctrl_sva.sv
// Port checker for the power state control block.
`timescale 1ns/1ps
module pmu_ctrl_sva (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic enable_pin,
	input wire logic global_reset_n,
	input wire logic valley_below_zero,
	input wire logic peak_below_mode,
	input wire logic peak_above_limit,
	input wire logic power_good_out,
	input wire pmu_pkg::pmu_reg_en_t reg_enable,
	input wire logic high_side_on,
	input wire logic low_side_on,
	input wire logic pulse_frequency_mode,
	input wire logic [8:0] current_limit_ma
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	logic [5:0] light_cnt;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			light_cnt <= 6'h00;
		end else if (!(valley_below_zero || peak_below_mode)) begin
			light_cnt <= 6'h00;
		end else if (light_cnt != 6'h3F) begin
			light_cnt <= light_cnt + 6'h01;
		end
	end
	off_when_low_a: assert property (!power_good_out |-> reg_enable == 4'h0)
		else $error("regulator on while power good low");
	active_all_on_a: assert property (power_good_out && reg_enable.core_en
		|-> reg_enable == 4'hF) else $error("active state regulator off");
	sleep_keep_a: assert property (power_good_out |-> reg_enable.pll_regulator
		&& reg_enable.io_regulator && reg_enable.retention_en)
		else $error("support regulator off while power good");
	powerup_pins_a: assert property ($rose(power_good_out)
		|-> $past(enable_pin, 60) && $past(global_reset_n, 60))
		else $error("power up without settled pins");
	pin_drop_a: assert property ($fell(enable_pin) || $fell(global_reset_n)
		|-> ##[1:6] !power_good_out) else $error("pin low ignored");
	no_overlap_a: assert property (!(high_side_on && low_side_on))
		else $error("both switches on");
	phase_order_a: assert property ($rose(low_side_on) && !pulse_frequency_mode
		|-> $past(high_side_on)) else $error("low phase without high phase");
	auto_delay_a: assert property ($rose(pulse_frequency_mode)
		|-> (light_cnt >= 6'd32) or ##[0:2] (current_limit_ma == 9'd100))
		else $error("pulse mode entered early");
	pfm_limit_a: assert property (pulse_frequency_mode && peak_above_limit
		|-> ##[1:3] !high_side_on) else $error("switch kept on past limit");
	low_limit_a: assert property (current_limit_ma == 9'd100
		|-> ##[0:2] pulse_frequency_mode) else $error("low limit outside pulse mode");
	cover property ($rose(power_good_out));
	cover property (power_good_out && !reg_enable.core_en);
	cover property ($rose(pulse_frequency_mode) && current_limit_ma == 9'd400);
endmodule : pmu_ctrl_sva
bind pmu_ctrl pmu_ctrl_sva i_sva (.clk_sys(clk_sys), .arst_n(arst_n),
	.enable_pin(enable_pin), .global_reset_n(global_reset_n),
	.valley_below_zero(valley_below_zero), .peak_below_mode(peak_below_mode),
	.peak_above_limit(peak_above_limit), .power_good_out(power_good_out),
	.reg_enable(reg_enable), .high_side_on(high_side_on),
	.low_side_on(low_side_on), .pulse_frequency_mode(pulse_frequency_mode),
	.current_limit_ma(current_limit_ma));

// >>> sim/pmu_ctrl_tb.sv
// Self-checking bench for the power state control block.
`timescale 1ns/1ps
`include "pmu_cfg.svh"
module pmu_ctrl_tb;
	logic clk_sys, arst_n, enable_pin, global_reset_n, psel, penable, pwrite;
	logic valley_below_zero, peak_below_mode, out_below_pfm_high;
	logic peak_above_limit, pready, pslverr, power_good_out, link_clk;
	logic host_data, link_data_out, link_data_oe, link_line;
	logic high_side_on, low_side_on, pulse_frequency_mode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic [6:0] core_volt_code, retention_supply_out;
	logic [8:0] current_limit_ma;
	logic [7:0] r;
	logic [32:0] e;
	logic [32:0] exp_q[$];
	pmu_pkg::pmu_reg_en_t reg_enable;
	int n_mismatch = 0;
	int num_checks = 0;
	int n;
	logic [31:0] seed = 32'h00000007;
	assign link_line = link_data_oe ? link_data_out : host_data;
	pmu_ctrl i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .enable_pin(enable_pin),
		.global_reset_n(global_reset_n), .link_clk(link_clk),
		.link_data_in(link_line), .link_data_out(link_data_out),
		.link_data_oe(link_data_oe), .valley_below_zero(valley_below_zero),
		.peak_below_mode(peak_below_mode), .out_below_pfm_high(out_below_pfm_high),
		.peak_above_limit(peak_above_limit), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .power_good_out(power_good_out),
		.reg_enable(reg_enable), .core_volt_code(core_volt_code),
		.retention_supply_out(retention_supply_out), .high_side_on(high_side_on),
		.low_side_on(low_side_on), .pulse_frequency_mode(pulse_frequency_mode),
		.current_limit_ma(current_limit_ma));
	pmu_link_host i_host (.link_clk(link_clk), .link_data(host_data),
		.link_line(link_line), .link_oe(link_data_oe));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] x);
		num_checks++;
		if (got !== x) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, x);
		end
	endtask : chk
	// Expected result is queued; the monitor below compares it at completion.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] x);
		exp_q.push_back(x);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) begin
			chk(32'h0, 32'h1);
			end_of_test();
		end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'h1) begin
			e = exp_q.pop_front();
			chk(pwrite ? {31'h0, pslverr} : prdata, pwrite ? {31'h0, e[32]} : e[31:0]);
		end
	end
	task automatic wait_pg(input logic x);
		n = 0;
		while (power_good_out !== x && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n < 400, 32'h1);
		if (n >= 400) end_of_test();
	endtask : wait_pg
	task automatic cnt_hs(input logic x);
		n = 0;
		while (high_side_on !== x && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 100) begin
			chk(n, 32'h0);
			end_of_test();
		end
	endtask : cnt_hs
	task automatic cmd(input logic [3:0] op, input logic [7:0] pl);
		i_host.send(op, pl);
		repeat (10) @(posedge clk_sys);
	endtask : cmd
	// Light load stays true throughout while the cause varies at random.
	task automatic light(input int len, input logic x);
		repeat (len) begin
			@(posedge clk_sys);
			v = xs();
			valley_below_zero <= v[0];
			peak_below_mode <= !v[0];
		end
		@(posedge clk_sys);
		chk(pulse_frequency_mode, x);
		valley_below_zero <= 1'h0;
		peak_below_mode <= 1'h0;
	endtask : light
	initial begin
		clk_sys = 1'h0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		{arst_n, enable_pin, global_reset_n, psel, penable, pwrite} = 6'h00;
		{valley_below_zero, peak_below_mode} = 2'h0;
		{out_below_pfm_high, peak_above_limit} = 2'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'h1;
		@(posedge clk_sys);
		chk(power_good_out, 32'h0);
		chk(reg_enable, 32'h0);
		apb(0, `PMU_ADDR_STATUS, 0, 0);
		apb(0, `PMU_ADDR_RETENTION, 0, `PMU_RETENTION_RESET);
		apb(1, `PMU_ADDR_CORE_VOLT, 32'h11, 0);
		apb(0, `PMU_ADDR_CORE_VOLT, 0, `PMU_CORE_VOLT_RESET);
		apb(1, 12'h020, 0, 33'h100000000);
		apb(0, 12'h020, 0, 0);
		enable_pin <= 1'h1;
		global_reset_n <= 1'h1;
		wait_pg(1);
		chk(reg_enable, 32'hF);
		chk(core_volt_code, `PMU_CORE_VOLT_RESET);
		apb(0, `PMU_ADDR_STATUS, 0, 5);
		cnt_hs(0);
		cnt_hs(1);
		cnt_hs(0);
		chk(n, 20);
		chk(low_side_on, 32'h1);
		cnt_hs(1);
		chk(n, `PMU_PWM_PERIOD_CYCLES - 20);
		v = xs() & 32'h7F;
		apb(1, `PMU_ADDR_CORE_VOLT, v, 0);
		repeat (2) @(posedge clk_sys);
		chk(core_volt_code, v);
		cmd(`PMU_CMD_CORE_ADJ, 8'h40);
		chk(core_volt_code, 32'h40);
		cmd(`PMU_CMD_AUTH, `PMU_AUTH_CODE);
		cmd(`PMU_CMD_REG_WRITE, 8'h85);
		i_host.send(`PMU_CMD_REG_READ, 8'h00);
		i_host.reply(r);
		chk(r, 32'h40);
		i_host.send(`PMU_CMD_REG_READ, 8'h01);
		i_host.reply(r);
		chk(r, 32'h5);
		cmd(`PMU_CMD_SLEEP, 8'h00);
		chk(power_good_out, 32'h1);
		chk(reg_enable, 32'h7);
		chk(retention_supply_out, 32'h5);
		cmd(`PMU_CMD_WAKEUP, 8'h00);
		chk(reg_enable, 32'hF);
		chk(core_volt_code, 32'h40);
		cmd(`PMU_CMD_SYNC, 8'h00);
		cmd(`PMU_CMD_REG_WRITE, 8'h87);
		apb(0, `PMU_ADDR_RETENTION, 0, 5);
		apb(1, `PMU_ADDR_MODE_FORCE, 2, 0);
		repeat (3) @(posedge clk_sys);
		chk(pulse_frequency_mode, 32'h1);
		chk(current_limit_ma, `PMU_PFM_LIMIT_MA);
		out_below_pfm_high <= 1'h1;
		repeat (4) @(posedge clk_sys);
		chk(high_side_on, 32'h1);
		peak_above_limit <= 1'h1;
		repeat (4) @(posedge clk_sys);
		chk(high_side_on, 32'h0);
		{out_below_pfm_high, peak_above_limit} <= 2'h0;
		apb(1, `PMU_ADDR_MODE_FORCE, 1, 0);
		light(40, 0);
		chk(current_limit_ma, `PMU_NORMAL_LIMIT_MA);
		apb(1, `PMU_ADDR_MODE_FORCE, 0, 0);
		light(20, 0);
		light(40, 1);
		cmd(`PMU_CMD_RESET, 8'h00);
		chk(core_volt_code, `PMU_CORE_VOLT_RESET);
		apb(1, `PMU_ADDR_CORE_VOLT, 32'h22, 0);
		cmd(`PMU_CMD_SHUTDOWN, 8'h00);
		chk(power_good_out, 32'h0);
		chk(core_volt_code, 32'h0);
		apb(0, `PMU_ADDR_CONTROL, 0, 1);
		enable_pin <= 1'h0;
		repeat (10) @(posedge clk_sys);
		chk(reg_enable, 32'h0);
		apb(0, `PMU_ADDR_STATUS, 0, 0);
		enable_pin <= 1'h1;
		wait_pg(1);
		chk(core_volt_code, `PMU_CORE_VOLT_RESET);
		apb(0, `PMU_ADDR_CONTROL, 0, 0);
		global_reset_n <= 1'h0;
		wait_pg(0);
		end_of_test();
	end
endmodule : pmu_ctrl_tb
